/* File: rtl/msrc_top.sv */
// Reset controller: gathers seven reset sources, sequences the reset pins and unit resets,
// latches straps, and exposes status and control over AHB-Lite.
// Assumes tap and watchdog/bus monitor events arrive on clk; pins arrive asynchronously.
//
// Overview of operation
// - Power-on resets everything, PLL too, drives both pins, samples configuration.
// - Straps are latched only by power-on reset, never by other sources.
// - Whenever hard reset is driven, soft reset is driven as well.
// - Hard reset pin is open drain; either side may pull it low.
// - A hard reset reloads features from the 32-bit hard configuration word.
// - External soft reset is seen only while the controller drives no reset.
// - Soft reset drives the soft pin (a boundary scan command only with tap_bscan_drives_soft), resets cores, keeps configuration.
// - Enabled watchdog expiry launches an internal hard reset sequence.
// - Enabled bus monitor expiry launches an internal hard reset sequence.
// - Test port reset command launches an internal soft reset sequence.
// - A status register records the sources of the latest reset.
// - Strap sampling, PLL reset, slave port config writes only at power-on.
// - System bus config writes and hard pin drive for power-on and hard.
// - Every reset source resets the peripheral bus modules.
// - Every reset source resets the cores and the multicore memory bus.
// - Internal power-on reset ends 1024 input clocks after the pin releases.
// - After PLL lock, hard pin releases at 512 and soft at 515 cycles.
// - Fourteen strap levels are captured as power-on reset releases.
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "msrc_cfg.svh"
module msrc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n_i,
  output logic hard_reset_n_o,
  output logic hard_reset_n_oe_n,
  input wire logic soft_reset_n_i,
  output logic soft_reset_n_o,
  output logic soft_reset_n_oe_n,
  input wire logic system_pll_lock,
  output logic system_pll_reset,
  input wire logic watchdog_expired,
  input wire logic bus_monitor_expired,
  input wire logic tap_reset_cmd,
  input wire logic tap_bscan_cmd,
  input wire logic tap_bscan_drives_soft,
  input wire msrc_pkg::msrc_straps_t config_straps,
  output var msrc_pkg::msrc_straps_t straps_latched,
  output var msrc_pkg::msrc_rst_t unit_resets,
  output logic slave_cfg_write_en,
  output logic sysbus_cfg_write_en,
  output logic hard_cfg_load,
  output logic [31:0] hard_cfg_word
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    msrc_pkg::msrc_state_t st;
    logic por_seq;
    logic soft_drv;
    logic [`MSRC_STATUS_W-1:0] status;
    logic [1:0] ctrl;
    logic [31:0] cfg_word;
    msrc_pkg::msrc_straps_t straps;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic ready;
    msrc_pkg::msrc_rst_t rst;
    logic hard_oe_n;
    logic soft_oe_n;
    logic pll_rst;
    logic dsi_cfg;
    logic bus_cfg;
    logic cfg_load;
  } msrc_regs_t;

  msrc_regs_t r;
  msrc_regs_t n;
  logic por_s;
  logic hard_s;
  logic soft_s;
  logic lock_s;
  msrc_pkg::msrc_straps_t straps_s;
  logic tmr_load;
  logic [`MSRC_TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic [`MSRC_STATUS_W-1:0] clr;
  logic [`MSRC_STATUS_W-1:0] src;
  logic wd_go;
  logic bm_go;
  logic hard_go;
  logic soft_go;

  function automatic logic hard_phase(input msrc_pkg::msrc_state_t s);
    hard_phase = (s == msrc_pkg::st_por_hold) || (s == msrc_pkg::st_por_delay) ||
                 (s == msrc_pkg::st_pll_wait) || (s == msrc_pkg::st_hard);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a, input msrc_regs_t x);
    case (a)
      `MSRC_OFS_STATUS: rd_word = {25'h0, x.status};
      `MSRC_OFS_CTRL: rd_word = {30'h0, x.ctrl};
      `MSRC_OFS_CFGWORD: rd_word = x.cfg_word;
      `MSRC_OFS_STRAPS: rd_word = {18'h0, x.straps};
      `MSRC_OFS_STATE: rd_word = {24'h0, x.st};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************************************
  // Pin synchronisers and phase timer
  // ****************************************************************
  // The straps ride the same two flops; they are only read after a long stable hold.
  msrc_sync #(
    .W(18),
    .RST_VAL({1'b0, 1'b1, 1'b1, 1'b0, 14'h0})
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({power_on_reset_n, hard_reset_n_i, soft_reset_n_i, system_pll_lock, config_straps}),
    .q({por_s, hard_s, soft_s, lock_s, straps_s})
  );

  msrc_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ****************************************************************
  // Source decode
  // ****************************************************************
  always_comb begin
    wd_go = watchdog_expired && r.ctrl[`MSRC_CTRL_WDOG_EN];
    bm_go = bus_monitor_expired && r.ctrl[`MSRC_CTRL_BMON_EN];
    hard_go = wd_go || bm_go || !hard_s;
    soft_go = !soft_s || tap_reset_cmd || tap_bscan_cmd;
    src = '0;
    src[`MSRC_ST_EXT_HARD] = !hard_s;
    src[`MSRC_ST_EXT_SOFT] = !soft_s;
    src[`MSRC_ST_WDOG] = wd_go;
    src[`MSRC_ST_BMON] = bm_go;
    src[`MSRC_ST_TAP_RST] = tap_reset_cmd;
    src[`MSRC_ST_TAP_BSCAN] = tap_bscan_cmd;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    tmr_load = 1'b0;
    tmr_val = '0;
    clr = '0;
    n.cfg_load = 1'b0;
    n.ready = 1'b1;
    if (r.dph_wr) begin
      case (r.dph_addr)
        `MSRC_OFS_STATUS: clr = hwdata[`MSRC_STATUS_W-1:0];
        `MSRC_OFS_CTRL: n.ctrl = hwdata[1:0];
        `MSRC_OFS_CFGWORD: n.cfg_word = hwdata;
        default: ;
      endcase
    end
    // A new sequence replaces the status below, so a clear never hides a fresh cause.
    n.status = r.status & ~clr;
    if (!por_s) begin
      if (r.st != msrc_pkg::st_por_hold) begin
        n.status = `MSRC_STATUS_RST;
      end
      n.st = msrc_pkg::st_por_hold;
      n.por_seq = 1'b1;
      n.soft_drv = 1'b1;
    end else begin
      case (r.st)
        msrc_pkg::st_por_hold: begin
          n.st = msrc_pkg::st_por_delay;
          n.straps = straps_s;
          tmr_load = 1'b1;
          tmr_val = `MSRC_TMR_W'(`MSRC_POR_DELAY_CYC - 1);
        end
        msrc_pkg::st_por_delay: begin
          if (tmr_done) begin
            n.st = msrc_pkg::st_pll_wait;
          end
        end
        msrc_pkg::st_pll_wait: begin
          if (lock_s) begin
            n.st = msrc_pkg::st_hard;
            n.cfg_load = 1'b1;
            tmr_load = 1'b1;
            tmr_val = `MSRC_TMR_W'(`MSRC_HARD_REL_CYC - 1);
          end
        end
        msrc_pkg::st_hard: begin
          if (tmr_done) begin
            n.st = msrc_pkg::st_soft_tail;
            tmr_load = 1'b1;
            tmr_val = `MSRC_TMR_W'(`MSRC_SOFT_TAIL_CYC - 1);
          end
        end
        msrc_pkg::st_soft_tail, msrc_pkg::st_soft: begin
          if (r.st == msrc_pkg::st_soft && hard_go) begin
            n.st = msrc_pkg::st_hard;
            n.status = src & ~(`MSRC_STATUS_W'(1) << `MSRC_ST_EXT_SOFT);
            n.soft_drv = 1'b1;
            n.cfg_load = 1'b1;
            tmr_load = 1'b1;
            tmr_val = `MSRC_TMR_W'(`MSRC_HARD_REL_CYC - 1);
          end else if (tmr_done) begin
            n.st = msrc_pkg::st_settle;
            tmr_load = 1'b1;
            tmr_val = `MSRC_TMR_W'(`MSRC_SETTLE_CLK - 1);
          end
        end
        msrc_pkg::st_settle: begin
          // Lets the released pins climb back through the synchronisers before they are watched.
          if (tmr_done) begin
            n.st = msrc_pkg::st_idle;
            n.por_seq = 1'b0;
          end
        end
        msrc_pkg::st_idle: begin
          if (hard_go) begin
            n.st = msrc_pkg::st_hard;
            n.status = src;
            n.soft_drv = 1'b1;
            n.cfg_load = 1'b1;
            tmr_load = 1'b1;
            tmr_val = `MSRC_TMR_W'(`MSRC_HARD_REL_CYC - 1);
          end else if (soft_go) begin
            n.st = msrc_pkg::st_soft;
            n.status = src;
            n.soft_drv = !soft_s || tap_reset_cmd || tap_bscan_drives_soft;
            tmr_load = 1'b1;
            tmr_val = `MSRC_TMR_W'(`MSRC_SOFT_HOLD_CYC - 1);
          end
        end
        default: begin
          n.st = msrc_pkg::st_idle;
        end
      endcase
    end
    // Outputs follow the next state so each pin and reset line leaves a flop.
    n.hard_oe_n = !hard_phase(n.st);
    n.soft_oe_n = !(hard_phase(n.st) || n.st == msrc_pkg::st_soft_tail ||
                    (n.st == msrc_pkg::st_soft && n.soft_drv));
    n.pll_rst = (n.st == msrc_pkg::st_por_hold) || (n.st == msrc_pkg::st_por_delay);
    n.rst.siu_reset_n = !hard_phase(n.st);
    n.rst.periph_reset_n = (n.st == msrc_pkg::st_idle) || (n.st == msrc_pkg::st_settle);
    n.rst.core_reset_n = n.rst.periph_reset_n;
    n.rst.multicore_memory_bus_reset_n = n.rst.periph_reset_n;
    n.dsi_cfg = hard_phase(n.st) && n.por_seq;
    n.bus_cfg = hard_phase(n.st);
    // Zero-wait slave: read data is taken from the updated copy, so a read right after a write sees it.
    n.dph_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.dph_wr = hwrite && (hsize == `MSRC_WORD_SIZE);
      n.dph_addr = (haddr[31:8] == 24'h0 && haddr[1:0] == 2'h0) ? haddr[7:0] : `MSRC_OFS_NONE;
      n.rdata = hwrite ? 32'h0000_0000 : rd_word(n.dph_addr, n);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '{st: msrc_pkg::st_por_hold, por_seq: 1'b1, soft_drv: 1'b1, status: `MSRC_STATUS_RST,
             ctrl: `MSRC_CTRL_RST, cfg_word: `MSRC_CFGWORD_RST, straps: '0, dph_wr: 1'b0,
             dph_addr: 8'h00, rdata: 32'h0000_0000, ready: 1'b1, rst: '0, hard_oe_n: 1'b0,
             soft_oe_n: 1'b0, pll_rst: 1'b1, dsi_cfg: 1'b1, bus_cfg: 1'b1, cfg_load: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.rdata;
  assign hreadyout = r.ready;
  assign hresp = 1'b0;
  assign hard_reset_n_o = 1'b0;
  assign soft_reset_n_o = 1'b0;
  assign hard_reset_n_oe_n = r.hard_oe_n;
  assign soft_reset_n_oe_n = r.soft_oe_n;
  assign system_pll_reset = r.pll_rst;
  assign straps_latched = r.straps;
  assign unit_resets = r.rst;
  assign slave_cfg_write_en = r.dsi_cfg;
  assign sysbus_cfg_write_en = r.bus_cfg;
  assign hard_cfg_load = r.cfg_load;
  assign hard_cfg_word = r.cfg_word;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  por_full_reset_a: assert property (r.st == msrc_pkg::st_por_hold |->
    system_pll_reset && !hard_reset_n_oe_n && !soft_reset_n_oe_n && !unit_resets.core_reset_n)
    else $error("power-on state without full reset");
  straps_por_only_a: assert property ($changed(straps_latched) |->
    $past(r.st) == msrc_pkg::st_por_hold)
    else $error("straps changed outside power-on release");
  hard_has_soft_a: assert property (!hard_reset_n_oe_n |-> !soft_reset_n_oe_n)
    else $error("hard pin driven without soft pin");
  hard_cfg_load_a: assert property ($rose(r.st == msrc_pkg::st_hard) |-> hard_cfg_load)
    else $error("hard entry without configuration load");
  soft_ext_idle_a: assert property ($rose(r.status[`MSRC_ST_EXT_SOFT]) &&
    r.st == msrc_pkg::st_soft |-> $past(r.st) == msrc_pkg::st_idle)
    else $error("external soft reset taken while busy");
  wdog_hard_a: assert property (r.st == msrc_pkg::st_idle && por_s && wd_go |=>
    r.st == msrc_pkg::st_hard ##1 !hard_reset_n_oe_n)
    else $error("watchdog expiry did not start hard reset");
  bmon_hard_a: assert property (r.st == msrc_pkg::st_idle && por_s && bm_go |=>
    r.st == msrc_pkg::st_hard && r.status[`MSRC_ST_BMON])
    else $error("bus monitor expiry did not start hard reset");
  tap_soft_a: assert property (r.st == msrc_pkg::st_idle && por_s && !hard_go && tap_reset_cmd |=>
    !soft_reset_n_oe_n && hard_reset_n_oe_n && !unit_resets.core_reset_n)
    else $error("tap reset command did not start soft reset");
  dsi_cfg_por_a: assert property (slave_cfg_write_en |-> r.por_seq && sysbus_cfg_write_en)
    else $error("slave port config write outside power-on");
  soft_keeps_cfg_a: assert property (r.st == msrc_pkg::st_soft |-> sysbus_cfg_write_en == 1'b0 &&
    unit_resets.siu_reset_n && $stable(straps_latched))
    else $error("soft reset touched configuration");
  busy_resets_a: assert property (r.st != msrc_pkg::st_idle && r.st != msrc_pkg::st_settle |->
    !unit_resets.periph_reset_n && !unit_resets.multicore_memory_bus_reset_n)
    else $error("unit resets missing during sequence");
  soft_after_hard_a: assert property ($rose(hard_reset_n_oe_n) && por_s |->
    (!soft_reset_n_oe_n)[*3] ##1 soft_reset_n_oe_n)
    else $error("soft pin not released three cycles after hard pin");
  por_delay_a: assert property ($rose(r.st == msrc_pkg::st_por_delay) && por_s |->
    (r.st == msrc_pkg::st_por_delay && system_pll_reset)[*8])
    else $error("power-on delay ended early");

endmodule // msrc_top
`default_nettype wire

/* File: inc/msrc_cfg.svh */
// Register offsets, field positions, reset values and sequence counts of the reset controller.
// Assumes clk stands in for both the input clock and the reference clock.
`ifndef MSRC_CFG_SVH
`define MSRC_CFG_SVH

// ****************************************************************
// Register map (byte offsets)
// ****************************************************************
`define MSRC_OFS_STATUS 8'h00
`define MSRC_OFS_CTRL 8'h04
`define MSRC_OFS_CFGWORD 8'h08
`define MSRC_OFS_STRAPS 8'h0C
`define MSRC_OFS_STATE 8'h10
`define MSRC_OFS_NONE 8'hFF

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define MSRC_ST_POR 0
`define MSRC_ST_EXT_HARD 1
`define MSRC_ST_EXT_SOFT 2
`define MSRC_ST_WDOG 3
`define MSRC_ST_BMON 4
`define MSRC_ST_TAP_RST 5
`define MSRC_ST_TAP_BSCAN 6
`define MSRC_STATUS_W 7
`define MSRC_STATUS_RST 7'h01
`define MSRC_CTRL_WDOG_EN 0
`define MSRC_CTRL_BMON_EN 1
`define MSRC_CTRL_RST 2'h3
`define MSRC_CFGWORD_RST 32'h0000_0000
`define MSRC_WORD_SIZE 3'h2

// ****************************************************************
// Sequence timing
// ****************************************************************
`define MSRC_CLK_PER_INPUT_CLOCK_PIN 1
`define MSRC_CLK_PER_REF_CLOCK 1
`define MSRC_POR_DELAY_INPUT_CLOCK_PIN 1024
`define MSRC_HARD_REL_REF_CLOCK 512
`define MSRC_SOFT_REL_REF_CLOCK 515
`define MSRC_SOFT_HOLD_REF_CLOCK 515
`define MSRC_SETTLE_CLK 4
`define MSRC_POR_DELAY_CYC (`MSRC_POR_DELAY_INPUT_CLOCK_PIN * `MSRC_CLK_PER_INPUT_CLOCK_PIN)
`define MSRC_HARD_REL_CYC (`MSRC_HARD_REL_REF_CLOCK * `MSRC_CLK_PER_REF_CLOCK)
`define MSRC_SOFT_TAIL_CYC ((`MSRC_SOFT_REL_REF_CLOCK - `MSRC_HARD_REL_REF_CLOCK) * `MSRC_CLK_PER_REF_CLOCK)
`define MSRC_SOFT_HOLD_CYC (`MSRC_SOFT_HOLD_REF_CLOCK * `MSRC_CLK_PER_REF_CLOCK)
`define MSRC_TMR_W 11

`endif

/* File: inc/msrc_pkg.sv */
// Types shared by the reset controller: sequence states, strap layout, reset groups.
// Assumes nothing of its surroundings.
package msrc_pkg;

  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_por_hold = 8'h02,
    st_por_delay = 8'h04,
    st_pll_wait = 8'h08,
    st_hard = 8'h10,
    st_soft_tail = 8'h20,
    st_soft = 8'h40,
    st_settle = 8'h80
  } msrc_state_t;

  typedef struct packed {
    logic reset_config_master_sel;
    logic config_source_sel;
    logic slave_port_sync_sel;
    logic slave_port_wide_sel;
    logic [3:0] chip_select_index;
    logic [2:0] boot_select;
    logic watchdog_enable_strap;
    logic [1:0] clock_mode_select;
  } msrc_straps_t;

  typedef struct packed {
    logic siu_reset_n;
    logic periph_reset_n;
    logic core_reset_n;
    logic multicore_memory_bus_reset_n;
  } msrc_rst_t;

endpackage

/* File: rtl/msrc_sync.sv */
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; multi-bit values are not kept coherent.
`timescale 1ns/100ps
`default_nettype none
module msrc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [1:0] ff_r;
    always_ff @(posedge clk) begin
      if (!resetn) begin
        ff_r <= {2{RST_VAL[i]}};
      end else begin
        ff_r <= {ff_r[0], d[i]};
      end
    end
    assign q[i] = ff_r[1];
  end

endmodule // msrc_sync
`default_nettype wire

/* File: rtl/msrc_timer.sv */
// Down counter that times each fixed-length phase of a reset sequence.
// Assumes the loader writes the phase length minus one on the phase's first edge.
`timescale 1ns/100ps
`default_nettype none
`include "msrc_cfg.svh"
module msrc_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [`MSRC_TMR_W-1:0] load_val,
  output logic done
);

  logic [`MSRC_TMR_W-1:0] cnt_r;
  logic [`MSRC_TMR_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - `MSRC_TMR_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == '0);

endmodule // msrc_timer
`default_nettype wire

/* File: verification/msrc_board.sv */
// Board-side model of the reset controller's far side: open-drain reset wires and a PLL.
// Assumes oe_n low means the device pulls a wire low; the bench drives the outside pullers.
`timescale 1ns/100ps
`default_nettype none
module msrc_board (
  input wire logic clk,
  input wire logic hard_oe_n,
  input wire logic soft_oe_n,
  input wire logic pull_hard,
  input wire logic pull_soft,
  input wire logic pll_reset,
  output logic hard_wire,
  output logic soft_wire,
  output logic pll_lock
);
  int lock_cnt = 0;
  // ****************************************************************
  // Wires and lock
  // ****************************************************************
  // Pull-ups hold a wire high only while nobody pulls it low.
  assign hard_wire = hard_oe_n & ~pull_hard;
  assign soft_wire = soft_oe_n & ~pull_soft;
  // Lock is lost while the PLL state is held in reset, so a slow lock is always exercised.
  always @(posedge clk) begin
    if (pll_reset === 1'b1) begin
      lock_cnt <= 0;
    end else if (lock_cnt < 30) begin
      lock_cnt <= lock_cnt + 1;
    end
  end
  assign pll_lock = (lock_cnt == 30);
endmodule // msrc_board
`default_nettype wire

/* File: verification/msrc_top_tb.sv */
// Self-checking bench of the reset controller with random straps and configuration words.
// Assumes the board model resolves the reset wires and locks the PLL after its reset.
`timescale 1ns/100ps
`default_nettype none
`include "msrc_cfg.svh"
module msrc_top_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, hard_oe_n, soft_oe_n, hard_wire, soft_wire, pll_lock, pll_reset;
  logic por_n = 1'b1;
  logic pull_hard = 1'b0;
  logic pull_soft = 1'b0;
  logic [3:0] ev = 4'h0;
  logic tap_drv = 1'b0;
  logic slave_en, sys_en, cfg_load;
  logic [31:0] cfg_word, d, cfg;
  msrc_pkg::msrc_straps_t straps = '0;
  msrc_pkg::msrc_straps_t straps_q;
  msrc_pkg::msrc_straps_t straps_por;
  logic hard_o, soft_o;
  msrc_pkg::msrc_rst_t ures;
  int errors = 0;
  int n_tests = 0;
  int seed, n_hard, n_soft, n_siu, n_core, n_load, n_sys, n_slave, n_pll;
  always #5 clk = ~clk;
  msrc_top u_msrc_top (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .power_on_reset_n(por_n), .hard_reset_n_i(hard_wire),
    .hard_reset_n_o(hard_o), .hard_reset_n_oe_n(hard_oe_n), .soft_reset_n_i(soft_wire), .soft_reset_n_o(soft_o),
    .soft_reset_n_oe_n(soft_oe_n), .system_pll_lock(pll_lock), .system_pll_reset(pll_reset),
    .watchdog_expired(ev[0]), .bus_monitor_expired(ev[1]), .tap_reset_cmd(ev[2]), .tap_bscan_cmd(ev[3]),
    .tap_bscan_drives_soft(tap_drv), .config_straps(straps), .straps_latched(straps_q),
    .unit_resets(ures), .slave_cfg_write_en(slave_en), .sysbus_cfg_write_en(sys_en),
    .hard_cfg_load(cfg_load), .hard_cfg_word(cfg_word));
  msrc_board u_msrc_board (.clk(clk), .hard_oe_n(hard_oe_n), .soft_oe_n(soft_oe_n), .pull_hard(pull_hard),
    .pull_soft(pull_soft), .pll_reset(pll_reset), .hard_wire(hard_wire), .soft_wire(soft_wire),
    .pll_lock(pll_lock));
  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
    n_tests++;
    if (got < lo || got > hi) fail($sformatf("%s count %0d outside %0d..%0d", what, got, lo, hi));
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fail("bus wait ran out");
        stop_test();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] w);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= `MSRC_WORD_SIZE;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= w;
    wait_rdy();
    d = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_val(d, exp, $sformatf("read %h", a));
    chk_val({29'h0, hresp, hard_o, soft_o}, 32'h0, "bus response and pin levels");
  endtask
  // Sequences end once both wires and all unit resets have been quiet for eight cycles,
  // which outlasts the settle phase so the next source is never refused as busy.
  task automatic run_seq();
    int idle;
    int k;
    {idle, k, n_hard, n_soft, n_siu, n_core, n_load, n_sys, n_slave, n_pll} = '0;
    while (idle < 8) begin
      #1;
      n_hard += (hard_wire === 1'b0);
      n_soft += (soft_wire === 1'b0);
      n_siu += (ures.siu_reset_n === 1'b0);
      n_core += (ures.core_reset_n === 1'b0 && ures.periph_reset_n === 1'b0 && ures.multicore_memory_bus_reset_n === 1'b0);
      n_load += (cfg_load === 1'b1);
      n_sys += (sys_en === 1'b1);
      n_slave += (slave_en === 1'b1);
      n_pll += (pll_reset === 1'b1);
      idle = (hard_wire === 1'b1 && soft_wire === 1'b1 && ures === 4'hF) ? idle + 1 : 0;
      @(posedge clk);
      k++;
      if (k > 3000) begin
        fail("reset sequence never ended");
        stop_test();
      end
    end
  endtask
  task automatic fire(input int w);
    ev[w] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
  endtask
  function automatic logic [31:0] st_bit(input int w);
    return 32'h1 << (w + `MSRC_ST_WDOG);
  endfunction
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 46;
    straps <= 14'($random(seed));
    cfg = $random(seed);
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    run_seq();
    chk_cnt(n_pll, `MSRC_POR_DELAY_CYC, `MSRC_POR_DELAY_CYC + 4, "pll reset");
    chk_cnt(n_slave, 1, 3000, "slave cfg window");
    chk_val(straps_q, straps, "latched straps");
    straps_por = straps;
    rd_chk(`MSRC_OFS_STATUS, 32'h1);
    rd_chk(`MSRC_OFS_CTRL, 32'h3);
    bus(1'b1, `MSRC_OFS_CFGWORD, cfg);
    rd_chk(`MSRC_OFS_CFGWORD, cfg);
    bus(1'b1, `MSRC_OFS_STRAPS, 32'hFFFF_FFFF);
    rd_chk(`MSRC_OFS_STRAPS, {18'h0, straps});
    rd_chk(8'h14, 32'h0);
    $display("test power_on done");
    straps <= 14'($random(seed));
    for (int i = 0; i < 5; i++) begin
      tap_drv <= (i == 4) ? 1'b1 : 1'($random(seed));
      @(posedge clk);
      fire(i > 3 ? 3 : i);
      run_seq();
      chk_cnt(n_hard, i < 2 ? 512 : 0, i < 2 ? 512 : 0, "hard wire");
      chk_cnt(n_soft, (i < 3 || tap_drv) ? 515 : 0, (i < 3 || tap_drv) ? 515 : 0, "soft wire");
      chk_cnt(n_siu, i < 2 ? 512 : 0, i < 2 ? 512 : 0, "siu reset");
      chk_cnt(n_core, 515, 515, "core periph bus reset");
      chk_cnt(n_load, i < 2, i < 2, "cfg load");
      chk_cnt(n_sys, i < 2, i < 2 ? 600 : 0, "sysbus cfg window");
      chk_cnt(n_slave + n_pll, 0, 0, "slave cfg and pll reset");
      chk_val(straps_q, straps_por, "straps kept");
      chk_val(straps_q ^ straps, straps_por ^ straps, "straps ignore pins");
      rd_chk(`MSRC_OFS_STRAPS, {18'h0, straps_por});
      rd_chk(`MSRC_OFS_STATUS, st_bit(i > 3 ? 3 : i));
      chk_val(cfg_word, cfg, "cfg word");
      $display("test source %0d done", i);
    end
    bus(1'b1, `MSRC_OFS_CTRL, 32'h0);
    fire(0);
    @(posedge clk);
    fire(1);
    run_seq();
    chk_cnt(n_core, 0, 0, "disabled events");
    bus(1'b1, `MSRC_OFS_CTRL, 32'h3);
    fire(0);
    repeat (100) @(posedge clk);
    pull_soft <= 1'b1;
    repeat (5) @(posedge clk);
    pull_soft <= 1'b0;
    run_seq();
    rd_chk(`MSRC_OFS_STATUS, 32'h8);
    bus(1'b1, `MSRC_OFS_STATUS, 32'h7F);
    rd_chk(`MSRC_OFS_STATUS, 32'h0);
    $display("test busy soft done");
    for (int i = 0; i < 2; i++) begin
      pull_soft <= (i == 0);
      pull_hard <= (i == 1);
      repeat (5) @(posedge clk);
      {pull_soft, pull_hard} <= 2'h0;
      run_seq();
      rd_chk(`MSRC_OFS_STATUS, i ? 32'h2 : 32'h4);
      // The pin answer lands three cycles into the five-cycle pull, so two driven cycles precede counting.
      chk_cnt(n_siu, i ? 510 : 0, i ? 510 : 0, "siu reset ext");
      chk_cnt(n_soft, i ? n_hard + 3 : 513, i ? n_hard + 3 : 513, "soft after hard");
      $display("test external %0d done", i);
    end
    fire(2);
    repeat (10) @(posedge clk);
    fire(0);
    run_seq();
    chk_cnt(n_hard, 512, 512, "soft upgraded to hard");
    rd_chk(`MSRC_OFS_STATUS, 32'h8);
    $display("test upgrade done");
    fire(2);
    repeat (50) @(posedge clk);
    straps <= 14'($random(seed));
    por_n <= 1'b0;
    repeat (20) @(posedge clk);
    por_n <= 1'b1;
    run_seq();
    rd_chk(`MSRC_OFS_STATUS, 32'h1);
    chk_val(straps_q, straps, "straps at power-on");
    chk_cnt(n_pll, `MSRC_POR_DELAY_CYC, `MSRC_POR_DELAY_CYC + 4, "pll reset");
    chk_cnt(n_slave, 1, 3000, "slave cfg window");
    $display("test mid-run power-on done");
    stop_test();
  end
endmodule // msrc_top_tb
`default_nettype wire
